/* File: inc/spwmg_pkg.sv */
// Functional notes
// [RQ1] bridge switches driven in diagonal pairs, first pair opposite second pair
// [RQ2] never command both transistors of one bridge leg on together
// [RQ3] square-wave mode: two antiphase square waves drive the two pairs
// [RQ4] primary output high while sine reference exceeds carrier, else low
// [RQ5] carrier frequency is an integer multiple of reference frequency
// [RQ6] over-modulation holds output constant through periods without crossing
// [RQ7] carrier is a PWM whose duty ramps linearly up and down
// [RQ8] complementary output is the inverse of the primary output
// [RQ9] primary output and complement drive the two transistors of one leg
// [RQ10] external reference is a sine at the inverter output frequency
// [RQ11] carrier period counter counts 0..249 on the 12.5 MHz tick, a 1000-clock PWM period
// [RQ12] phase counter counts 0..24, each ramp lasts 25 carrier periods
// [RQ13] one full rise and fall of duty spans one millisecond
// [RQ14] duty changes by equal steps and reverses at minimum and maximum
// [RQ15] all counters run on one clock and clear to zero on reset
package spwmg_pkg;
	localparam int         CLK_HZ         = 50000000;
	localparam int         CARRIER_CLK_HZ = 12500000;
	localparam logic [1:0] CLK_DIV_LAST   =
		2'(CLK_HZ / CARRIER_CLK_HZ - 1);
	localparam logic [7:0] PERIOD_LAST    = 8'hF9;
	localparam logic [4:0] PHASE_LAST     = 5'h18;
	localparam int         DUTY_STEPS     = 25;
	localparam logic [7:0] DUTY_STEP      =
		8'((int'(PERIOD_LAST) + 1) / 2 / DUTY_STEPS);
	localparam logic [7:0] DUTY_MAX       = 8'(DUTY_STEP * DUTY_STEPS);
	localparam int         REF_SYNC_LEN   = 2;
	localparam logic [15:0] SQ_HALF_LAST  = 16'h0F9F;
endpackage : spwmg_pkg

/* File: rtl/spwmg_top.sv */
`timescale 1ns/100ps
module spwmg_top (
	input  wire logic CLK,
	input  wire logic RESET,
	input  wire logic SQUARE_MODE,
	input  wire logic REF_ABOVE_CARRIER,
	output logic      CARRIER_PWM,
	output logic      PAIR_A_FIRST_SWITCH,
	output logic      PAIR_A_SECOND_SWITCH,
	output logic      PAIR_B_FIRST_SWITCH,
	output logic      PAIR_B_SECOND_SWITCH
);
	logic [1:0]  clk_div_q;
	logic [7:0]  carrier_period_counter_q;
	logic [7:0]  carrier_duty_counter_q;
	logic [4:0]  phase_step_counter_q;
	logic        ramp_down_q;
	logic [1:0]  ref_sync_q;
	logic [1:0]  mode_sync_q;
	logic [15:0] sq_count_q;
	logic        sq_phase_q;
	logic        primary_q;
	logic        tick;
	logic        period_end;
	logic        phase_end;
	logic        duty_top;
	logic        duty_bottom;
	logic        carrier_d;
	logic        primary_d;

	// divider: carrier logic advances at 12.5 MHz
	assign tick        = (clk_div_q == spwmg_pkg::CLK_DIV_LAST);
	assign period_end  = tick &&
		(carrier_period_counter_q == spwmg_pkg::PERIOD_LAST); // RQ11
	assign phase_end   = period_end &&
		(phase_step_counter_q == spwmg_pkg::PHASE_LAST); // RQ12
	assign duty_top    = (carrier_duty_counter_q == spwmg_pkg::DUTY_MAX);
	assign duty_bottom = (carrier_duty_counter_q == 8'h00);
	// pwm high while position below the duty compare
	assign carrier_d   = (carrier_period_counter_q <
		carrier_duty_counter_q); // RQ7
	// sine above carrier gives high; no crossing gives no edge
	assign primary_d   = mode_sync_q[1] ? sq_phase_q
		: ref_sync_q[1]; // RQ4 RQ6 RQ3

	always_ff @(posedge CLK) begin
		if (RESET) begin
			clk_div_q <= 2'h0; // RQ15
		end else if (tick) begin
			clk_div_q <= 2'h0;
		end else begin
			clk_div_q <= clk_div_q + 2'h1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			carrier_period_counter_q <= 8'h00; // RQ15
		end else if (period_end) begin
			carrier_period_counter_q <= 8'h00; // RQ11
		end else if (tick) begin
			carrier_period_counter_q <= carrier_period_counter_q + 8'h01;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			phase_step_counter_q <= 5'h00; // RQ15
		end else if (phase_end) begin
			phase_step_counter_q <= 5'h00; // RQ12
		end else if (period_end) begin
			phase_step_counter_q <= phase_step_counter_q + 5'h01;
		end
	end

	// one step per carrier period, direction flips at the ends
	always_ff @(posedge CLK) begin
		if (RESET) begin
			carrier_duty_counter_q <= 8'h00; // RQ15
			ramp_down_q            <= 1'b0;
		end else if (period_end) begin
			if (phase_end) begin
				ramp_down_q <= ~ramp_down_q; // RQ14 RQ13 RQ5
			end
			if (ramp_down_q && !duty_bottom) begin
				carrier_duty_counter_q <= carrier_duty_counter_q
					- spwmg_pkg::DUTY_STEP; // RQ14
			end else if (!ramp_down_q && !duty_top) begin
				carrier_duty_counter_q <= carrier_duty_counter_q
					+ spwmg_pkg::DUTY_STEP; // RQ14
			end
		end
	end

	// square-wave mode: fixed half period at the carrier rate
	always_ff @(posedge CLK) begin
		if (RESET) begin
			sq_count_q <= 16'h0000;
			sq_phase_q <= 1'b0;
		end else if (tick) begin
			if (sq_count_q == spwmg_pkg::SQ_HALF_LAST) begin
				sq_count_q <= 16'h0000;
				sq_phase_q <= ~sq_phase_q; // RQ3
			end else begin
				sq_count_q <= sq_count_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			ref_sync_q  <= 2'h0;
			mode_sync_q <= 2'h0;
		end else begin
			ref_sync_q  <= {ref_sync_q[0], REF_ABOVE_CARRIER};
			mode_sync_q <= {mode_sync_q[0], SQUARE_MODE};
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			primary_q            <= 1'b0;
			CARRIER_PWM          <= 1'b0;
			PAIR_A_FIRST_SWITCH  <= 1'b0;
			PAIR_A_SECOND_SWITCH <= 1'b0;
			PAIR_B_FIRST_SWITCH  <= 1'b0;
			PAIR_B_SECOND_SWITCH <= 1'b0;
		end else begin
			primary_q            <= primary_d;
			CARRIER_PWM          <= carrier_d; // RQ7
			PAIR_A_FIRST_SWITCH  <= primary_d; // RQ1 RQ4
			PAIR_A_SECOND_SWITCH <= primary_d; // RQ1
			PAIR_B_FIRST_SWITCH  <= ~primary_d; // RQ8 RQ2
			PAIR_B_SECOND_SWITCH <= ~primary_d; // RQ8 RQ2
		end
	end

	property p_leg_exclusive;
		@(posedge CLK) disable iff (RESET)
		!(PAIR_A_FIRST_SWITCH && PAIR_B_SECOND_SWITCH) &&
		!(PAIR_A_SECOND_SWITCH && PAIR_B_FIRST_SWITCH);
	endproperty
	a_leg_exclusive: assert property (p_leg_exclusive) // RQ2
		else $error("both transistors of one leg on");

	// outputs still hold their reset zeros on the first edge after release
	property p_pairs;
		@(posedge CLK) disable iff (RESET)
		!$past(RESET) |->
		(PAIR_A_FIRST_SWITCH == PAIR_A_SECOND_SWITCH) &&
		(PAIR_B_FIRST_SWITCH == PAIR_B_SECOND_SWITCH) &&
		(PAIR_A_FIRST_SWITCH != PAIR_B_FIRST_SWITCH);
	endproperty
	a_pairs: assert property (p_pairs) // RQ1
		else $error("switch pairs not diagonal and opposite");

	property p_complement;
		@(posedge CLK) disable iff (RESET)
		!$past(RESET) |-> PAIR_B_FIRST_SWITCH == ~primary_q;
	endproperty
	a_complement: assert property (p_complement) // RQ8
		else $error("complement not inverse of primary");

	property p_compare;
		@(posedge CLK) disable iff (RESET)
		!mode_sync_q[1] ##1 !$past(RESET)
		|-> PAIR_A_FIRST_SWITCH == $past(ref_sync_q[1]);
	endproperty
	a_compare: assert property (p_compare) // RQ4
		else $error("primary does not follow comparison");

	property p_hold;
		@(posedge CLK) disable iff (RESET)
		(!mode_sync_q[1] && ref_sync_q[1] && $stable(ref_sync_q[1]))
		##1 (!mode_sync_q[1] && ref_sync_q[1])
		|=> $stable(PAIR_A_FIRST_SWITCH);
	endproperty
	a_hold: assert property (p_hold) // RQ6
		else $error("edge without crossing");

	property p_period_wrap;
		@(posedge CLK) disable iff (RESET)
		period_end |=> carrier_period_counter_q == 8'h00;
	endproperty
	a_period_wrap: assert property (p_period_wrap) // RQ11
		else $error("carrier period counter wrap wrong");

	property p_period_len;
		@(posedge CLK) disable iff (RESET)
		period_end |=> !period_end [*8];
	endproperty
	a_period_len: assert property (p_period_len) // RQ11
		else $error("carrier period too short");

	property p_duty_bounds;
		@(posedge CLK) disable iff (RESET)
		carrier_duty_counter_q <= spwmg_pkg::DUTY_MAX;
	endproperty
	a_duty_bounds: assert property (p_duty_bounds) // RQ14
		else $error("duty out of range");

	property p_duty_step;
		@(posedge CLK) disable iff (RESET)
		period_end && !ramp_down_q && !duty_top |=>
		carrier_duty_counter_q ==
			$past(carrier_duty_counter_q) + spwmg_pkg::DUTY_STEP;
	endproperty
	a_duty_step: assert property (p_duty_step) // RQ14
		else $error("duty step wrong");

	property p_phase_wrap;
		@(posedge CLK) disable iff (RESET)
		phase_end |=> phase_step_counter_q == 5'h00;
	endproperty
	a_phase_wrap: assert property (p_phase_wrap) // RQ12
		else $error("phase counter wrap wrong");

	property p_reset_zero;
		@(posedge CLK) RESET |=> carrier_period_counter_q == 8'h00 &&
			phase_step_counter_q == 5'h00 && clk_div_q == 2'h0;
	endproperty
	a_reset_zero: assert property (p_reset_zero) // RQ15
		else $error("counters not cleared by reset");
endmodule : spwmg_top

/* File: verification/spwmg_ref_model.sv */
`timescale 1ns/100ps
module spwmg_ref_model (
	input  wire logic clk,
	input  wire logic above,
	output logic      cmp_out
);
	// comparator answer moves just after the falling edge
	initial cmp_out = 1'h0;
	always @(negedge clk) begin
		#1 cmp_out <= above;
	end
endmodule : spwmg_ref_model

/* File: verification/test_sinusoidal_pwm_gate_generator.sv */
`timescale 1ns/100ps
module test_sinusoidal_pwm_gate_generator;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic sq_mode = 1'h0;
	logic above = 1'h0;
	logic ref_cmp, carrier, a1, a2, b1, b2;
	int   miscompares = 0;
	int   n_compared = 0;
	int   cycles = 0;
	int   w1, w2, p, n;

	always #10 clk = ~clk;

	spwmg_ref_model u_spwmg_ref_model (.clk(clk), .above(above),
		.cmp_out(ref_cmp));

	spwmg_top u_spwmg_top (.CLK(clk), .RESET(reset), .SQUARE_MODE(sq_mode),
		.REF_ABOVE_CARRIER(ref_cmp), .CARRIER_PWM(carrier),
		.PAIR_A_FIRST_SWITCH(a1), .PAIR_A_SECOND_SWITCH(a2),
		.PAIR_B_FIRST_SWITCH(b1), .PAIR_B_SECOND_SWITCH(b2));

	task automatic close_out;
		if (miscompares == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	task automatic check(input string name, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	always @(posedge clk) begin
		cycles++;
		if (cycles == 100000) begin
			miscompares++;
			close_out();
		end
	end

	// drive the reference, expect old value for 2 edges, new on the 3rd
	task automatic t_step(input logic lvl, input logic [3:0] exp);
		@(negedge clk);
		above = lvl;
		repeat (2) @(posedge clk);
		#1 check("no_early", 32'(a1), 32'(!lvl));
		@(posedge clk);
		#1 check("pairs", 32'({a1, a2, b1, b2}), 32'(exp));
	endtask : t_step

	// hold the reference high: no edge, legs never both on
	task automatic t_overmod;
		n = 0;
		repeat (1000) begin
			@(posedge clk);
			#1 if (a1 !== 1'h1 || b1 !== 1'h0 || b2 !== 1'h0) n++;
		end
		check("held", 32'(n), 32'h0);
	endtask : t_overmod

	// starts at the first falling edge of a high phase, ends at the next one
	task automatic pulse(output int hi, output int per);
		hi = 0;
		per = 0;
		while (carrier) begin
			hi++;
			per++;
			@(negedge clk);
		end
		while (!carrier) begin
			per++;
			@(negedge clk);
		end
	endtask : pulse

	task automatic t_carrier;
		repeat (3000) @(posedge clk);
		@(posedge carrier);
		@(negedge clk);
		pulse(w1, p);
		check("period", 32'(p), 32'h3E8);
		pulse(w2, p);
		check("period_next", 32'(p), 32'h3E8);
		check("duty_step", 32'(w2 > w1 ? w2 - w1 : w1 - w2), 32'h14);
	endtask : t_carrier

	task automatic wait_toggle;
		logic prev;
		n = 0;
		prev = a1;
		do begin
			@(negedge clk);
			n++;
		end while (a1 === prev && n < 40000);
	endtask : wait_toggle

	task automatic t_square;
		@(negedge clk);
		sq_mode = 1'h1;
		wait_toggle();
		wait_toggle();
		check("sq_half", 32'(n), 32'h3E80);
		check("sq_anti", 32'({a1, a2, b1, b2}), 32'h3);
	endtask : t_square

	initial begin
		repeat (12) @(negedge clk);
		check("reset", 32'({carrier, a1, a2, b1, b2}), 32'h0);
		reset = 1'h0;
		t_step(1'h1, 4'hC);
		t_overmod();
		t_step(1'h0, 4'h3);
		t_carrier();
		t_square();
		close_out();
	end
endmodule : test_sinusoidal_pwm_gate_generator
